// File: rtl/rcc_pkg.sv
// Package of the reset cause controller: register map, fields, timing, state and carrier types.
// Assumes one 100 MHz APB clock domain; offsets are word indexes, byte address is four times the index.
package rcc_pkg;

    // Register indexes; the bus byte address is four times each index
    localparam logic [31:0] CTRL_INDEX  = 32'h00C40000;
    localparam logic [31:0] CAUSE_INDEX = 32'h00C40001;
    localparam logic [31:0] RSVD2_INDEX = 32'h00C40002;
    localparam logic [31:0] RSVD3_INDEX = 32'h00C40003;

    // Control byte fields
    localparam int CTRL_SW_BIT    = 7;
    localparam int CTRL_FORCE_BIT = 6;
    localparam int CTRL_FLAG_BIT  = 4;
    localparam int CTRL_IE_BIT    = 3;
    localparam int CTRL_RE_BIT    = 2;
    localparam int CTRL_SE_BIT    = 1;
    localparam int CTRL_EN_BIT    = 0;
    localparam logic [7:0] CTRL_RESET = 8'h00;
    localparam logic [7:0] CTRL_WMASK = 8'hCF;

    // Cause byte fields
    localparam int CAUSE_BO_BIT  = 7;
    localparam int CAUSE_SW_BIT  = 6;
    localparam int CAUSE_WD_BIT  = 5;
    localparam int CAUSE_POR_BIT = 4;
    localparam int CAUSE_PIN_BIT = 3;
    localparam int CAUSE_LOC_BIT = 2;
    localparam int CAUSE_LOL_BIT = 1;
    localparam logic [7:0] CAUSE_RESET = 8'h90;

    // Timing counts, in system clock cycles
    localparam int PIN_MIN_EDGES = 4;
    localparam int COUNT_CYCLES  = 512;

    typedef enum logic [2:0] {
        ST_RUN      = 3'b000,
        ST_WAIT_BUS = 3'b001,
        ST_PIN_WAIT = 3'b011,
        ST_LOCK     = 3'b010,
        ST_COUNT    = 3'b110,
        ST_RELEASE  = 3'b111
    } rcc_state_e;

    typedef struct packed {
        logic        psel;
        logic        penable;
        logic        pwrite;
        logic [31:0] paddr;
        logic [31:0] pwdata;
    } rcc_apb_req_s;

    typedef struct packed {
        logic        pready;
        logic [31:0] prdata;
        logic        pslverr;
    } rcc_apb_rsp_s;

    typedef struct packed {
        logic por_request;
        logic watchdog_timeout;
        logic clock_loss;
        logic lock_loss;
        logic low_voltage;
        logic pll_locked;
        logic stop_mode;
        logic bus_cycle_end;
    } rcc_src_s;

endpackage : rcc_pkg

// File: rtl/rcc_pin_filter.sv
// External reset pin conditioner: two-stage synchroniser and a run-length qualifier.
// Assumes the pin is active low and may change at any time relative to pclk.
`timescale 1ns/100ps
module rcc_pin_filter
    import rcc_pkg::*;
(
    input  wire logic pclk,
    input  wire logic presetn,
    input  wire logic pin_n,
    output logic      pin_low,
    output logic      recognized
);
    typedef struct packed {
        logic       meta;
        logic       sync;
        logic [2:0] run;
        logic       rec;
    } rcc_pf_s;

    rcc_pf_s st;
    rcc_pf_s next_st;

    always_comb
    begin
        next_st      = st;
        next_st.meta = pin_n;
        next_st.sync = st.meta;
        if (st.sync)
        begin
            next_st.run = 3'h0;
            next_st.rec = 1'b0;
        end
        else if (st.run != 3'(PIN_MIN_EDGES))
        begin
            next_st.run = st.run + 3'h1;
        end
        next_st.rec = !st.sync && (next_st.run == 3'(PIN_MIN_EDGES));
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            st <= '{meta: 1'b1, sync: 1'b1, run: 3'h0, rec: 1'b0};
        else
            st <= next_st;
    end

    assign pin_low    = !st.sync;
    assign recognized = st.rec;
endmodule : rcc_pin_filter

// File: rtl/rcc_cycle_counter.sv
// Reset stretch counter: counts while run is high, restarts on clear.
// Assumes run and clear come from the sequencer in the same domain.
`timescale 1ns/100ps
module rcc_cycle_counter
    import rcc_pkg::*;
#(
    parameter int CYCLES = COUNT_CYCLES
)
(
    input  wire logic pclk,
    input  wire logic presetn,
    input  wire logic run,
    input  wire logic clear,
    output logic      done
);
    localparam int W = $clog2(CYCLES + 1);

    initial
    begin
        if (CYCLES < 1)
            $error("CYCLES must be at least 1");
    end

    logic [W-1:0] cnt;
    logic [W-1:0] next_cnt;

    always_comb
    begin
        next_cnt = cnt;
        if (clear)
            next_cnt = '0;
        else if (run && cnt != W'(CYCLES))
            next_cnt = cnt + W'(1);
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            cnt <= '0;
        else
            cnt <= next_cnt;
    end

    assign done = (cnt == W'(CYCLES));
endmodule : rcc_cycle_counter

// File: rtl/rcc_top.sv
// Reset cause controller: collects reset requests, sequences the chip reset, records the cause.
// Assumes an APB master on pclk, and that presetn is the power-on event itself.
// How it works
// - Reset pin is synchronised except in stop mode, where it acts directly.
// - Outside stop mode, pin request counts only after four consecutive low clock edges.
// - Reset output is active low and low while the chip is held.
// - Two reserved bytes ignore writes and read as zero.
// - Both registers answer regardless of access privilege.
// - Software request bit starts a reset; that reset clears it.
// - Force bit drives reset output low independent of chip reset state.
// - Brownout flag sets on detected low voltage when enabled; write one clears.
// - Brownout interrupt needs enable, interrupt enable, and no reset enable.
// - Interrupt, reset and stop enables act only with brownout enable set.
// - With reset and interrupt both enabled, brownout gives a reset.
// - Stop enable keeps detection alive in stop mode, else it is off.
// - Brownout enable switches low-voltage detection on and off.
// - Cause byte on entry holds pending causes only, replacing the old record.
// - Cause byte is readable anytime; writes leave it unchanged.
// - Separate cause bits for brownout, software, watchdog, power-on, pin, clock, lock.
// - Pin, watchdog, software are synchronous; the others act asynchronously.
// - Synchronous requests wait for bus cycle end, then reset next edge.
// - Bus monitor is forced on while waiting for the bus cycle end.
// - Writes in flight complete intact when a synchronous reset occurs.
// - Asynchronous requests assert reset at once without waiting for the bus.
// - Held reset waits pin negation and lock, then 512 cycles, then releases.
// - Pin request during lock wait or count returns to pin negation wait.
// - Power-on sets power-on and brownout causes only, ignoring others meanwhile.
`timescale 1ns/100ps
module rcc_top
    import rcc_pkg::*;
#(
    parameter int STRETCH_CYCLES = COUNT_CYCLES
)
(
    input  wire logic           pclk,
    input  wire logic           presetn,
    input  wire rcc_pkg::rcc_apb_req_s apb_req,
    output rcc_pkg::rcc_apb_rsp_s      apb_rsp,
    input  wire rcc_pkg::rcc_src_s     src,
    input  wire logic           ext_reset_n,
    output logic                reset_output_n,
    output logic                chip_reset_n,
    output logic                bus_watch_force,
    output logic                brownout_detect,
    output logic                brownout_irq,
    output logic                config_sample
);
    import rcc_pkg::*;

    initial
    begin
        if (STRETCH_CYCLES < 1)
            $error("STRETCH_CYCLES must be at least 1");
    end

    localparam logic [31:0] CTRL_ADDR  = {CTRL_INDEX[29:0], 2'b00};
    localparam logic [31:0] CAUSE_ADDR = {CAUSE_INDEX[29:0], 2'b00};
    localparam logic [31:0] RSVD2_ADDR = {RSVD2_INDEX[29:0], 2'b00};
    localparam logic [31:0] RSVD3_ADDR = {RSVD3_INDEX[29:0], 2'b00};

    typedef struct packed {
        rcc_state_e   state;
        logic [7:0]   ctrl;
        logic [7:0]   cause;
        logic [7:0]   pend;
        logic         por_seq;
        rcc_apb_rsp_s rsp;
        logic         rst_out_n;
        logic         chip_n;
        logic         watch;
        logic         detect;
        logic         irq;
        logic         sample;
    } rcc_top_s;

    rcc_top_s st;
    rcc_top_s next_st;

    logic pin_low;
    logic pin_rec;
    logic cnt_done;
    logic cnt_run;
    logic cnt_clear;

    rcc_pin_filter u_pin
    (
        .pclk       (pclk),
        .presetn    (presetn),
        .pin_n      (ext_reset_n),
        .pin_low    (pin_low),
        .recognized (pin_rec)
    );

    rcc_cycle_counter #(.CYCLES(STRETCH_CYCLES)) u_cnt
    (
        .pclk    (pclk),
        .presetn (presetn),
        .run     (cnt_run),
        .clear   (cnt_clear),
        .done    (cnt_done)
    );

    assign cnt_run   = (st.state == ST_COUNT);
    assign cnt_clear = (st.state != ST_COUNT);

    // Brownout decode
    logic bo_en;
    logic bo_detect_on;
    logic bo_event;
    logic bo_reset_req;
    logic bo_irq_req;

    always_comb
    begin
        bo_en        = st.ctrl[CTRL_EN_BIT];
        // Detection off in stop mode unless the stop enable keeps it
        bo_detect_on = bo_en && (!src.stop_mode || st.ctrl[CTRL_SE_BIT]);
        bo_event     = bo_detect_on && src.low_voltage;
        bo_reset_req = bo_event && st.ctrl[CTRL_RE_BIT];
        // Reset enable takes priority over the interrupt
        bo_irq_req   = bo_en && st.ctrl[CTRL_IE_BIT]
                       && !st.ctrl[CTRL_RE_BIT];
    end

    // Request classification
    logic pin_stop_req;
    logic async_req;
    logic sync_req;
    logic [7:0] sync_bits;
    logic [7:0] async_bits;
    logic hold;

    always_comb
    begin
        // In stop mode the raw pin acts without the filter
        pin_stop_req = src.stop_mode && !ext_reset_n;
        sync_bits    = 8'h00;
        sync_bits[CAUSE_PIN_BIT] = pin_rec && !src.stop_mode;
        sync_bits[CAUSE_WD_BIT]  = src.watchdog_timeout;
        sync_bits[CAUSE_SW_BIT]  = st.ctrl[CTRL_SW_BIT];
        async_bits   = 8'h00;
        async_bits[CAUSE_LOC_BIT] = src.clock_loss;
        async_bits[CAUSE_LOL_BIT] = src.lock_loss;
        async_bits[CAUSE_PIN_BIT] = pin_stop_req;
        sync_req     = |sync_bits;
        async_req    = |async_bits;
        hold         = (st.state == ST_PIN_WAIT) || (st.state == ST_LOCK)
                       || (st.state == ST_COUNT) || (st.state == ST_RELEASE);
    end

    // APB decode; privilege is not checked, so any master reaches both bytes
    logic        setup;
    logic        access;
    logic        hit_ctrl;
    logic        hit_cause;
    logic        hit_rsvd;
    logic [31:0] rd_word;

    always_comb
    begin
        setup     = apb_req.psel && !apb_req.penable;
        access    = apb_req.psel && apb_req.penable && st.rsp.pready;
        hit_ctrl  = (apb_req.paddr == CTRL_ADDR);
        hit_cause = (apb_req.paddr == CAUSE_ADDR);
        hit_rsvd  = (apb_req.paddr == RSVD2_ADDR) || (apb_req.paddr == RSVD3_ADDR);
        rd_word   = 32'h0000_0000;
        if (hit_ctrl)
            rd_word[7:0] = st.ctrl;
        else if (hit_cause)
            rd_word[7:0] = st.cause;
    end

    always_comb
    begin
        next_st = st;

        // Bus slave: answer in the access phase after each setup
        next_st.rsp.pready = setup;
        if (setup)
        begin
            next_st.rsp.prdata  = apb_req.pwrite ? 32'h0000_0000 : rd_word;
            next_st.rsp.pslverr = !(hit_ctrl || hit_cause || hit_rsvd);
        end
        else if (!apb_req.psel)
        begin
            next_st.rsp.prdata  = 32'h0000_0000;
            next_st.rsp.pslverr = 1'b0;
        end

        // Control writes; cause and reserved bytes ignore writes
        if (access && apb_req.pwrite && hit_ctrl)
        begin
            next_st.ctrl = (st.ctrl & ~CTRL_WMASK) | (apb_req.pwdata[7:0] & CTRL_WMASK);
            // Write one clears the brownout flag
            next_st.ctrl[CTRL_FLAG_BIT] = st.ctrl[CTRL_FLAG_BIT] && !apb_req.pwdata[CTRL_FLAG_BIT];
        end
        // A new low-voltage event wins over a clear in the same cycle
        if (bo_event)
            next_st.ctrl[CTRL_FLAG_BIT] = 1'b1;

        // Sequencer
        case (st.state)
            ST_RUN:
            begin
                if (async_req)
                begin
                    // No wait for the bus cycle
                    next_st.cause = async_bits | sync_bits;
                    next_st.pend  = 8'h00;
                    next_st.state = pin_stop_req ? ST_PIN_WAIT : ST_LOCK;
                end
                else if (sync_req)
                begin
                    next_st.pend  = sync_bits;
                    next_st.state = ST_WAIT_BUS;
                end
            end
            ST_WAIT_BUS:
            begin
                next_st.pend = st.pend | sync_bits;
                if (async_req)
                begin
                    // Clock or lock loss ends the wait; both kinds are recorded
                    next_st.cause = st.pend | sync_bits | async_bits;
                    next_st.pend  = 8'h00;
                    next_st.state = ST_PIN_WAIT;
                end
                else if (src.bus_cycle_end)
                begin
                    // In-flight write finishes before reset lands
                    next_st.cause = st.pend | sync_bits;
                    next_st.pend  = 8'h00;
                    next_st.state = ST_PIN_WAIT;
                end
            end
            ST_PIN_WAIT:
            begin
                if (!pin_low)
                    next_st.state = ST_LOCK;
            end
            ST_LOCK:
            begin
                if (pin_rec)
                    next_st.state = ST_PIN_WAIT;
                else if (src.pll_locked && !src.lock_loss && !src.clock_loss)
                    next_st.state = ST_COUNT;
            end
            ST_COUNT:
            begin
                if (pin_rec)
                    next_st.state = ST_PIN_WAIT;
                else if (src.lock_loss || src.clock_loss || !src.pll_locked)
                    next_st.state = ST_LOCK;
                else if (cnt_done)
                    next_st.state = ST_RELEASE;
            end
            ST_RELEASE:
            begin
                next_st.state   = ST_RUN;
                next_st.por_seq = 1'b0;
            end
            default:
            begin
                next_st.state = ST_LOCK;
            end
        endcase

        // Brownout reset restarts any sequence at once
        if (bo_reset_req)
        begin
            next_st.state = ST_LOCK;
            next_st.pend  = 8'h00;
            if (!st.por_seq)
            begin
                next_st.cause = 8'h00;
                next_st.cause[CAUSE_BO_BIT] = 1'b1;
            end
        end

        // A power-on sequence keeps its own record to the end
        if (src.por_request)
        begin
            next_st.state   = ST_LOCK;
            next_st.pend    = 8'h00;
            next_st.por_seq = 1'b1;
        end
        if (next_st.por_seq)
            next_st.cause = CAUSE_RESET;

        // Entering reset clears the software request
        if (next_st.state inside {ST_PIN_WAIT, ST_LOCK} && !hold)
            next_st.ctrl[CTRL_SW_BIT] = 1'b0;

        // Registered outputs
        next_st.chip_n = !(next_st.state inside {ST_PIN_WAIT, ST_LOCK, ST_COUNT, ST_RELEASE});
        // Force bit acts on the pin alone, not on the chip reset
        next_st.rst_out_n = next_st.chip_n && !next_st.ctrl[CTRL_FORCE_BIT];
        next_st.watch     = (next_st.state == ST_WAIT_BUS);
        next_st.detect    = bo_detect_on;
        next_st.irq       = bo_irq_req && next_st.ctrl[CTRL_FLAG_BIT];
        // Override data is sampled while the output is still low
        next_st.sample    = (next_st.state == ST_RELEASE);
    end

    localparam rcc_top_s TOP_RESET = '{
        state:     ST_LOCK,
        ctrl:      CTRL_RESET,
        cause:     CAUSE_RESET,
        pend:      8'h00,
        por_seq:   1'b1,
        rsp:       '{pready: 1'b0, prdata: 32'h0000_0000, pslverr: 1'b0},
        rst_out_n: 1'b0,
        chip_n:    1'b0,
        watch:     1'b0,
        detect:    1'b0,
        irq:       1'b0,
        sample:    1'b0
    };

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            st <= TOP_RESET;
        else
            st <= next_st;
    end

    assign apb_rsp         = st.rsp;
    assign reset_output_n  = st.rst_out_n;
    assign chip_reset_n    = st.chip_n;
    assign bus_watch_force = st.watch;
    assign brownout_detect = st.detect;
    assign brownout_irq    = st.irq;
    assign config_sample   = st.sample;

endmodule : rcc_top

// File: testbench/rcc_top_sva.sv
// Checker of the reset cause controller, watching only the top ports.
// Assumes one pclk domain with presetn as its reset.
`timescale 1ns/100ps
module rcc_top_sva
    import rcc_pkg::*;
#(
    parameter int STRETCH_CYCLES = COUNT_CYCLES
)
(
    input wire logic                  pclk,
    input wire logic                  presetn,
    input wire rcc_pkg::rcc_apb_req_s apb_req,
    input wire rcc_pkg::rcc_apb_rsp_s apb_rsp,
    input wire rcc_pkg::rcc_src_s     src,
    input wire logic                  ext_reset_n,
    input wire logic                  reset_output_n,
    input wire logic                  chip_reset_n,
    input wire logic                  bus_watch_force,
    input wire logic                  brownout_detect,
    input wire logic                  brownout_irq,
    input wire logic                  config_sample
);
    logic [15:0] quiet_cnt;
    logic        async_req;
    assign async_req = src.clock_loss | src.lock_loss | src.por_request | src.low_voltage | src.stop_mode;
    // Raw pin is ahead of the synchroniser, but a low pin clears this count at once and the real one only once recognised
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            quiet_cnt <= '0;
        else if (chip_reset_n || !ext_reset_n || !src.pll_locked)
            quiet_cnt <= '0;
        else
            quiet_cnt <= quiet_cnt + 16'h0001;
    end
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    sequence s_bus_wait;
        chip_reset_n && bus_watch_force && !src.bus_cycle_end && !async_req;
    endsequence
    sequence s_bus_done;
        chip_reset_n && bus_watch_force && src.bus_cycle_end;
    endsequence
    a_sync_holds: assert property (s_bus_wait |=> chip_reset_n)
        else $error("reset asserted before the bus cycle ended");
    a_sync_enters: assert property (s_bus_done |=> !chip_reset_n && !bus_watch_force)
        else $error("reset not asserted after the bus cycle ended");
    a_watch_forced: assert property (chip_reset_n && !bus_watch_force && src.watchdog_timeout && !async_req
        |=> bus_watch_force)
        else $error("bus monitor not forced for a synchronous request");
    a_async_fast: assert property (chip_reset_n && (src.clock_loss || src.lock_loss || src.por_request)
        |=> !chip_reset_n && !reset_output_n)
        else $error("asynchronous request did not reset at once");
    a_output_low: assert property (!chip_reset_n |-> !reset_output_n)
        else $error("reset output high while chip held");
    a_release_mark: assert property ($rose(chip_reset_n) |-> $past(config_sample))
        else $error("release without the sample cycle");
    a_stretch_len: assert property ($rose(chip_reset_n) |-> quiet_cnt >= STRETCH_CYCLES)
        else $error("reset released before the stretch count");
    a_ready_next: assert property (apb_req.psel && !apb_req.penable |=> apb_rsp.pready)
        else $error("no ready after setup");
    a_ready_only: assert property (apb_rsp.pready |-> apb_req.psel && apb_req.penable)
        else $error("ready outside an access cycle");
    a_upper_zero: assert property (apb_rsp.pready |-> apb_rsp.prdata[31:8] == 24'h000000)
        else $error("upper read data not zero");
    a_irq_gate: assert property (brownout_irq |-> brownout_detect)
        else $error("brownout interrupt with detection off");
endmodule : rcc_top_sva
bind rcc_top rcc_top_sva #(.STRETCH_CYCLES(STRETCH_CYCLES)) i_sva (.pclk(pclk), .presetn(presetn),
    .apb_req(apb_req), .apb_rsp(apb_rsp), .src(src), .ext_reset_n(ext_reset_n),
    .reset_output_n(reset_output_n), .chip_reset_n(chip_reset_n), .bus_watch_force(bus_watch_force),
    .brownout_detect(brownout_detect), .brownout_irq(brownout_irq), .config_sample(config_sample));

// File: testbench/rcc_board.sv
// Board model: external reset pin with pull-up and configuration override drivers.
// Assumes the bench calls hold_pin right after a pclk edge.
`timescale 1ns/100ps
module rcc_board
#(
    parameter logic [7:0] OVERRIDE = 8'h5A
)
(
    input  wire logic       pclk,
    input  wire logic       reset_output_n,
    output logic            ext_reset_n,
    output logic [7:0]      cfg_bus
);
    logic [7:0] last_cfg;
    initial ext_reset_n = 1'b1;
    initial last_cfg = 8'h00;
    always @(posedge pclk)
        last_cfg <= cfg_bus;
    // Released bus shows a toggling pattern so a stale value cannot pass
    assign cfg_bus = reset_output_n ? ~last_cfg : OVERRIDE;
    task hold_pin(input int cycles);
        @(posedge pclk);
        ext_reset_n <= 1'b0;
        repeat (cycles) @(posedge pclk);
        ext_reset_n <= 1'b1;
    endtask : hold_pin
endmodule : rcc_board

// File: testbench/testbench.sv
// Self-checking bench of the reset cause controller.
// Assumes the board model drives the pin; the stretch count is cut to 8.
`timescale 1ns/100ps
module testbench;
    import rcc_pkg::*;
    typedef struct packed {
        logic        w;
        logic [31:0] a;
        logic [7:0]  d;
        logic [7:0]  e;
        logic        x;
    } rcc_row_s;
    localparam logic [31:0] AC = CTRL_INDEX << 2;
    localparam logic [31:0] AS = CAUSE_INDEX << 2;
    localparam logic [31:0] A2 = RSVD2_INDEX << 2;
    localparam logic [31:0] A3 = RSVD3_INDEX << 2;
    localparam logic [31:0] AX = AC + 32'h00000010;
    logic         pclk;
    logic         presetn;
    rcc_apb_req_s req;
    rcc_apb_rsp_s rsp;
    rcc_src_s     src;
    logic         ext_reset_n, reset_output_n, chip_reset_n, bus_watch_force;
    logic         brownout_detect, brownout_irq, config_sample;
    logic [7:0]   cfg_bus;
    logic [31:0]  rd;
    logic         er;
    int           err_total;
    int           total_checks;
    rcc_row_s rows [11] = '{'{1'b0, AS, 8'h00, 8'h90, 1'b0}, '{1'b1, AS, 8'hFF, 8'h00, 1'b0},
        '{1'b0, AS, 8'h00, 8'h90, 1'b0}, '{1'b1, A2, 8'hFF, 8'h00, 1'b0}, '{1'b0, A2, 8'h00, 8'h00, 1'b0},
        '{1'b1, A3, 8'hFF, 8'h00, 1'b0}, '{1'b0, A3, 8'h00, 8'h00, 1'b0}, '{1'b0, AX, 8'h00, 8'h00, 1'b1},
        '{1'b1, AX, 8'hFF, 8'h00, 1'b1}, '{1'b1, AC, 8'h2E, 8'h00, 1'b0}, '{1'b0, AC, 8'h00, 8'h0E, 1'b0}};
    rcc_top #(.STRETCH_CYCLES(8)) i_dut (.pclk(pclk), .presetn(presetn), .apb_req(req), .apb_rsp(rsp),
        .src(src), .ext_reset_n(ext_reset_n), .reset_output_n(reset_output_n), .chip_reset_n(chip_reset_n),
        .bus_watch_force(bus_watch_force), .brownout_detect(brownout_detect), .brownout_irq(brownout_irq),
        .config_sample(config_sample));
    rcc_board i_board (.pclk(pclk), .reset_output_n(reset_output_n), .ext_reset_n(ext_reset_n),
        .cfg_bus(cfg_bus));
    always #5 pclk = ~pclk;
    task fail(input string what);
        err_total++;
        $display("[ERR] %0t %s", $time, what);
    endtask : fail
    task check(input logic [31:0] got, input logic [31:0] exp, input string what);
        total_checks++;
        if (got !== exp)
            $display("[ERR] %0t %s got %h expected %h", $time, what, got, exp);
        if (got !== exp)
            err_total++;
    endtask : check
    task finish_test;
        $display("checks %0d mismatches %0d", total_checks, err_total);
        if (err_total == 0 && total_checks > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask : finish_test
    task tick(input int n);
        repeat (n) @(posedge pclk);
    endtask : tick
    task apb(input logic w, input logic [31:0] a, input logic [7:0] d);
        int n;
        req.psel <= 1'b1;
        req.penable <= 1'b0;
        req.pwrite <= w;
        req.paddr <= a;
        req.pwdata <= {24'h000000, d};
        @(posedge pclk);
        req.penable <= 1'b1;
        n = 0;
        do
        begin
            @(posedge pclk);
            n++;
        end
        while (rsp.pready !== 1'b1 && n < 16);
        if (n >= 16)
            fail("no ready");
        rd = rsp.prdata;
        er = rsp.pslverr;
        req.psel <= 1'b0;
        req.penable <= 1'b0;
        @(posedge pclk);
    endtask : apb
    task rdchk(input logic [31:0] a, input logic [7:0] e);
        apb(1'b0, a, 8'h00);
        check(rd, {24'h000000, e}, "read data");
    endtask : rdchk
    task wait_rel;
        int n;
        n = 0;
        while (chip_reset_n !== 1'b1 && n < 300)
        begin
            @(posedge pclk);
            n++;
        end
        if (n >= 300)
            fail("reset never released");
        if (n >= 300)
            finish_test();
    endtask : wait_rel
    initial
    begin
        repeat (100000) @(posedge pclk);
        fail("run timeout");
        finish_test();
    end
    initial
    begin
        pclk = 1'b0;
        presetn = 1'b0;
        req = '0;
        src = '0;
        src.pll_locked = 1'b1;
        src.bus_cycle_end = 1'b1;
        err_total = 0;
        total_checks = 0;
        tick(5);
        check(reset_output_n, 1'b0, "held output");
        check(cfg_bus, 8'h5A, "override");
        presetn <= 1'b1;
        wait_rel();
        foreach (rows[i])
        begin
            apb(rows[i].w, rows[i].a, rows[i].d);
            if (!rows[i].w)
                check(rd, {24'h000000, rows[i].e}, "row data");
            check(er, rows[i].x, "row error");
        end
        src.low_voltage <= 1'b1;
        tick(3);
        src.low_voltage <= 1'b0;
        check(brownout_detect, 1'b0, "detect off");
        check(chip_reset_n, 1'b1, "no brownout reset");
        rdchk(AC, 8'h0E);
        $display("registers done");
        apb(1'b1, AC, 8'h40);
        tick(2);
        check(reset_output_n, 1'b0, "forced low");
        check(chip_reset_n, 1'b1, "chip runs");
        apb(1'b1, AC, 8'h09);
        tick(2);
        check(reset_output_n, 1'b1, "force off");
        check(brownout_detect, 1'b1, "detect on");
        src.low_voltage <= 1'b1;
        tick(1);
        src.low_voltage <= 1'b0;
        tick(3);
        check(brownout_irq, 1'b1, "irq raised");
        rdchk(AC, 8'h19);
        apb(1'b1, AC, 8'h19);
        tick(2);
        check(brownout_irq, 1'b0, "irq cleared");
        rdchk(AC, 8'h09);
        apb(1'b1, AC, 8'h0D);
        src.low_voltage <= 1'b1;
        tick(1);
        src.low_voltage <= 1'b0;
        tick(2);
        check(chip_reset_n, 1'b0, "brownout reset");
        check(brownout_irq, 1'b0, "no irq on reset");
        wait_rel();
        rdchk(AS, 8'h80);
        apb(1'b1, AC, 8'h10);
        $display("brownout done");
        src.bus_cycle_end <= 1'b0;
        src.watchdog_timeout <= 1'b1;
        tick(1);
        src.watchdog_timeout <= 1'b0;
        tick(3);
        check(bus_watch_force, 1'b1, "monitor forced");
        check(chip_reset_n, 1'b1, "waits for bus");
        src.bus_cycle_end <= 1'b1;
        tick(3);
        check(chip_reset_n, 1'b0, "watchdog reset");
        wait_rel();
        rdchk(AS, 8'h20);
        apb(1'b1, AC, 8'h80);
        tick(3);
        check(chip_reset_n, 1'b0, "software reset");
        wait_rel();
        rdchk(AS, 8'h40);
        rdchk(AC, 8'h00);
        $display("synchronous done");
        i_board.hold_pin(3);
        tick(8);
        check(chip_reset_n, 1'b1, "short pin ignored");
        i_board.hold_pin(4);
        tick(6);
        check(chip_reset_n, 1'b0, "pin reset");
        check(cfg_bus, 8'h5A, "override");
        wait_rel();
        rdchk(AS, 8'h08);
        for (int i = 0; i < 2; i++)
        begin
            src.clock_loss <= (i == 0);
            src.lock_loss <= (i == 1);
            src.pll_locked <= 1'b0;
            tick(1);
            src.clock_loss <= 1'b0;
            src.lock_loss <= 1'b0;
            tick(1);
            check(chip_reset_n, 1'b0, "async reset");
            tick(30);
            check(chip_reset_n, 1'b0, "waits lock");
            src.pll_locked <= 1'b1;
            wait_rel();
            rdchk(AS, 8'h04 >> i);
        end
        $display("asynchronous done");
        presetn <= 1'b0;
        tick(2);
        presetn <= 1'b1;
        wait_rel();
        rdchk(AS, 8'h90);
        rdchk(AC, 8'h00);
        $display("power-on done");
        finish_test();
    end
endmodule : testbench
